// ---- logic/csfa_pkg.sv ----
package csfa_pkg;
	// Register byte offsets on the Avalon-MM slave
	localparam int AVS_AW = 5;
	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_ACC = 5'h04;
	localparam logic [4:0] OFF_IDX = 5'h08;
	localparam logic [4:0] OFF_STAT = 5'h0C;
	localparam logic [4:0] OFF_SP = 5'h10;
	localparam logic [4:0] OFF_MPTR = 5'h14;
	localparam logic [4:0] OFF_MDATA = 5'h18;

	// Command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BIT_LSB = 8;
	localparam int CMD_BUSY_BIT = 16;

	// Status word bit positions
	localparam int FLG_C = 0;
	localparam int FLG_Z = 1;
	localparam int FLG_I = 2;
	localparam int FLG_D = 3;
	localparam int FLG_B = 4;
	localparam int FLG_T = 5;
	localparam int FLG_V = 6;
	localparam int FLG_N = 7;

	// Reset values and memory map
	localparam logic [7:0] STAT_RST = 8'h04;
	localparam logic [7:0] SP_RST = 8'hFF;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] WO_BASE = 8'hF0;

	typedef enum logic [4:0] {
		op_add_with_carry = 5'b00000,
		op_subtract_with_borrow = 5'b00001,
		op_and = 5'b00010,
		op_exclusive_or = 5'b00011,
		op_inclusive_or = 5'b00100,
		op_clear_bit = 5'b00101,
		op_set_bit = 5'b00110,
		op_shift_left_arith = 5'b00111,
		op_logical_shift_right = 5'b01000,
		op_rotate_left = 5'b01001,
		op_rotate_right = 5'b01010,
		op_nibble_rotate = 5'b01011,
		op_subtract_one = 5'b01100,
		op_add_one = 5'b01101,
		op_product_op = 5'b01110,
		op_quotient_op = 5'b01111,
		op_push_status = 5'b10000,
		op_pull_status = 5'b10001,
		op_decimal_flag_set_op = 5'b10010,
		op_decimal_flag_clear_op = 5'b10011,
		op_carry_set = 5'b10100,
		op_carry_clear = 5'b10101,
		op_mem_mode_set = 5'b10110,
		op_mem_mode_clear = 5'b10111,
		op_none = 5'b11111
	} csfa_op_t;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_fetch = 2'b01,
		st_exec = 2'b10
	} csfa_fsm_t;

	typedef struct packed {
		csfa_fsm_t fsm;
		csfa_op_t op;
		logic [2:0] bitsel;
		logic [7:0] acc;
		logic [7:0] idx;
		logic [7:0] status;
		logic [7:0] sp;
		logic [7:0] mptr;
		logic [7:0] tmp_a;
		logic [7:0] tmp_b;
		logic [7:0] open_bus;
		logic busy;
		logic waitrequest;
		logic [31:0] readdata;
	} csfa_state_t;

	function automatic logic is_rmw(input csfa_op_t op);
		return (op >= op_clear_bit) && (op <= op_add_one);
	endfunction

	function automatic logic is_combine(input csfa_op_t op);
		return op <= op_inclusive_or;
	endfunction

	function automatic logic is_wo(input logic [7:0] addr);
		return addr >= WO_BASE;
	endfunction
endpackage

// ---- logic/csfa_alu.sv ----
`timescale 1ns/1ps
module csfa_alu
	import csfa_pkg::*;
(
	// Operation and operands
	input wire csfa_pkg::csfa_op_t op,
	input wire logic [7:0] a,
	input wire logic [7:0] a_hi,
	input wire logic [7:0] b,
	input wire logic [2:0] bitsel,
	input wire logic carry_in,
	input wire logic decimal,
	// Results
	output logic [7:0] res,
	output logic [7:0] res_hi,
	output logic c_out,
	output logic v_out,
	output logic upd_c,
	output logic upd_zn,
	output logic upd_v
);
	// Half-adjust one packed-decimal digit; returns {digit_carry, digit}
	function automatic logic [4:0] bcd_add_digit(input logic [4:0] raw);
		return (raw > 5'h09) ? 5'(raw + 5'h06) | 5'h10 : raw;
	endfunction

	function automatic logic [4:0] bcd_sub_digit(input logic [4:0] raw);
		return raw[4] ? (5'(raw - 5'h06) | 5'h10) : raw;
	endfunction

	logic [8:0] bin_sum;
	logic [4:0] lo_d;
	logic [4:0] hi_d;
	logic [15:0] wide;

	always_comb begin
		res = a;
		res_hi = 8'h00;
		c_out = carry_in;
		v_out = 1'b0;
		upd_c = 1'b0;
		upd_zn = 1'b0;
		upd_v = 1'b0;
		bin_sum = 9'h000;
		lo_d = 5'h00;
		hi_d = 5'h00;
		wide = 16'h0000;
		case (op)
			op_add_with_carry: begin
				upd_c = 1'b1;
				if (decimal) begin
					// Packed decimal; N, V and Z carry no meaning and are left alone
					lo_d = bcd_add_digit(5'({1'b0, a[3:0]}) + 5'({1'b0, b[3:0]}) + 5'({4'h0, carry_in}));
					hi_d = bcd_add_digit(5'({1'b0, a[7:4]}) + 5'({1'b0, b[7:4]}) + 5'({4'h0, lo_d[4]}));
					res = {hi_d[3:0], lo_d[3:0]};
					c_out = hi_d[4];
				end else begin
					bin_sum = 9'({1'b0, a}) + 9'({1'b0, b}) + 9'({8'h00, carry_in});
					res = bin_sum[7:0];
					c_out = bin_sum[8];
					v_out = (a[7] == b[7]) && (bin_sum[7] != a[7]);
					upd_zn = 1'b1;
					upd_v = 1'b1;
				end
			end
			op_subtract_with_borrow: begin
				upd_c = 1'b1;
				if (decimal) begin
					lo_d = bcd_sub_digit(5'({1'b0, a[3:0]}) - 5'({1'b0, b[3:0]}) - 5'({4'h0, ~carry_in}));
					hi_d = bcd_sub_digit(5'({1'b0, a[7:4]}) - 5'({1'b0, b[7:4]}) - 5'({4'h0, lo_d[4]}));
					res = {hi_d[3:0], lo_d[3:0]};
					// Carry set means no borrow, cleared means borrow
					c_out = ~hi_d[4];
				end else begin
					bin_sum = 9'({1'b0, a}) + 9'({1'b0, ~b}) + 9'({8'h00, carry_in});
					res = bin_sum[7:0];
					c_out = bin_sum[8];
					v_out = (a[7] != b[7]) && (bin_sum[7] != a[7]);
					upd_zn = 1'b1;
					upd_v = 1'b1;
				end
			end
			op_and: begin
				res = a & b;
				upd_zn = 1'b1;
			end
			op_exclusive_or: begin
				res = a ^ b;
				upd_zn = 1'b1;
			end
			op_inclusive_or: begin
				res = a | b;
				upd_zn = 1'b1;
			end
			// Read-modify-write class
			op_clear_bit: res = a & ~(8'h01 << bitsel);
			op_set_bit: res = a | (8'h01 << bitsel);
			op_shift_left_arith: begin
				res = {a[6:0], 1'b0};
				c_out = a[7];
				upd_c = 1'b1;
				upd_zn = 1'b1;
			end
			op_logical_shift_right: begin
				res = {1'b0, a[7:1]};
				c_out = a[0];
				upd_c = 1'b1;
				upd_zn = 1'b1;
			end
			op_rotate_left: begin
				res = {a[6:0], carry_in};
				c_out = a[7];
				upd_c = 1'b1;
				upd_zn = 1'b1;
			end
			op_rotate_right: begin
				res = {carry_in, a[7:1]};
				c_out = a[0];
				upd_c = 1'b1;
				upd_zn = 1'b1;
			end
			op_nibble_rotate: res = {a[3:0], a[7:4]};
			op_subtract_one: begin
				res = 8'(a - 8'h01);
				upd_zn = 1'b1;
			end
			op_add_one: begin
				res = 8'(a + 8'h01);
				upd_zn = 1'b1;
			end
			// Binary register form only, no flag touched
			op_product_op: begin
				wide = 16'({8'h00, a}) * 16'({8'h00, b});
				res = wide[7:0];
				res_hi = wide[15:8];
			end
			op_quotient_op: begin
				if (b == 8'h00) begin
					// Divide by zero saturates rather than leaving the registers stale
					res = 8'hFF;
					res_hi = 8'hFF;
				end else begin
					wide = {a_hi, a} / {8'h00, b};
					res = wide[7:0];
					wide = {a_hi, a} % {8'h00, b};
					res_hi = wide[7:0];
				end
			end
			default: res = a;
		endcase
	end
endmodule

// ---- logic/csfa_core.sv ----
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module csfa_core
	import csfa_pkg::*;
#(
	parameter int MEM_DEPTH = 256
) (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST_B,
	// Avalon-MM slave
	input wire logic [csfa_pkg::AVS_AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Core state
	output logic [7:0] STATUS_WORD,
	output logic CORE_BUSY
);
	csfa_state_t st_ff;
	csfa_state_t nxt_st;
	logic [7:0] mem_ff [MEM_DEPTH];
	logic mem_we;
	logic [7:0] mem_wa;
	logic [7:0] mem_wd;
	logic [7:0] alu_a;
	logic [7:0] alu_res;
	logic [7:0] alu_res_hi;
	logic alu_c;
	logic alu_v;
	logic alu_upd_c;
	logic alu_upd_zn;
	logic alu_upd_v;
	logic req;

	// Write-only locations answer with whatever the internal bus last carried
	function automatic logic [7:0] peek(input logic [7:0] addr, input logic [7:0] last);
		return is_wo(addr) ? last : mem_ff[addr];
	endfunction

	assign alu_a = (st_ff.op == op_product_op || st_ff.op == op_quotient_op) ? st_ff.acc : st_ff.tmp_a;

	csfa_alu i_csfa_alu (
		.op(st_ff.op),
		.a(alu_a),
		.a_hi(st_ff.idx),
		.b(st_ff.tmp_b),
		.bitsel(st_ff.bitsel),
		.carry_in(st_ff.status[FLG_C]),
		.decimal(st_ff.status[FLG_D]),
		.res(alu_res),
		.res_hi(alu_res_hi),
		.c_out(alu_c),
		.v_out(alu_v),
		.upd_c(alu_upd_c),
		.upd_zn(alu_upd_zn),
		.upd_v(alu_upd_v)
	);

	assign req = AVS_READ | AVS_WRITE;

	always_comb begin
		nxt_st = st_ff;
		mem_we = 1'b0;
		mem_wa = 8'h00;
		mem_wd = 8'h00;
		nxt_st.waitrequest = 1'b1;
		// One ack per request; commands and accesses wait while an operation runs
		if (req && st_ff.waitrequest && st_ff.fsm == st_idle) begin
			nxt_st.waitrequest = 1'b0;
			nxt_st.readdata = 32'h0000_0000;
			if (AVS_READ) begin
				case ({AVS_ADDRESS[4:2], 2'b00})
					OFF_CMD: nxt_st.readdata = {15'h0000, st_ff.busy, 5'h00, st_ff.bitsel, 3'h0, st_ff.op};
					OFF_ACC: nxt_st.readdata = {24'h000000, st_ff.acc};
					OFF_IDX: nxt_st.readdata = {24'h000000, st_ff.idx};
					OFF_STAT: nxt_st.readdata = {24'h000000, st_ff.status};
					OFF_SP: nxt_st.readdata = {24'h000000, st_ff.sp};
					OFF_MPTR: nxt_st.readdata = {24'h000000, st_ff.mptr};
					OFF_MDATA: begin
						nxt_st.readdata = {24'h000000, peek(st_ff.mptr, st_ff.open_bus)};
						nxt_st.open_bus = peek(st_ff.mptr, st_ff.open_bus);
					end
					default: nxt_st.readdata = 32'h0000_0000;
				endcase
			end else if (AVS_BYTEENABLE[0]) begin
				case ({AVS_ADDRESS[4:2], 2'b00})
					OFF_CMD: begin
						nxt_st.op = csfa_op_t'(AVS_WRITEDATA[CMD_OP_LSB +: 5]);
						nxt_st.bitsel = AVS_WRITEDATA[CMD_BIT_LSB +: 3];
						nxt_st.fsm = st_fetch;
						nxt_st.busy = 1'b1;
					end
					OFF_ACC: nxt_st.acc = AVS_WRITEDATA[7:0];
					OFF_IDX: nxt_st.idx = AVS_WRITEDATA[7:0];
					OFF_STAT: nxt_st.status = AVS_WRITEDATA[7:0];
					OFF_SP: nxt_st.sp = AVS_WRITEDATA[7:0];
					OFF_MPTR: nxt_st.mptr = AVS_WRITEDATA[7:0];
					OFF_MDATA: begin
						mem_we = 1'b1;
						mem_wa = st_ff.mptr;
						mem_wd = AVS_WRITEDATA[7:0];
						nxt_st.open_bus = AVS_WRITEDATA[7:0];
					end
					default: nxt_st.op = st_ff.op;
				endcase
			end
		end

		case (st_ff.fsm)
			st_idle: nxt_st.busy = nxt_st.busy;
			st_fetch: begin
				nxt_st.fsm = st_exec;
				if (st_ff.op == op_pull_status) begin
					nxt_st.tmp_a = peek(8'(st_ff.sp + 8'h01), st_ff.open_bus);
				end else if (is_rmw(st_ff.op)) begin
					// One byte read from the addressed location
					nxt_st.tmp_a = peek(st_ff.mptr, st_ff.open_bus);
					nxt_st.open_bus = peek(st_ff.mptr, st_ff.open_bus);
				end else if (is_combine(st_ff.op) || st_ff.op == op_product_op || st_ff.op == op_quotient_op) begin
					// Memory-operand mode takes the first operand from memory at IDX; multiply and divide still feed ACC to the ALU
					nxt_st.tmp_a = st_ff.status[FLG_T] ? peek(st_ff.idx, st_ff.open_bus) : st_ff.acc;
					nxt_st.tmp_b = peek(st_ff.mptr, st_ff.open_bus);
					nxt_st.open_bus = peek(st_ff.mptr, st_ff.open_bus);
				end
			end
			st_exec: begin
				nxt_st.fsm = st_idle;
				nxt_st.busy = 1'b0;
				case (st_ff.op)
					op_push_status: begin
						// Stack grows down, so the saved word sits at SP+1 afterwards
						mem_we = 1'b1;
						mem_wa = st_ff.sp;
						mem_wd = st_ff.status;
						nxt_st.open_bus = st_ff.status;
						nxt_st.sp = 8'(st_ff.sp - 8'h01);
					end
					op_pull_status: begin
						nxt_st.status = st_ff.tmp_a;
						nxt_st.sp = 8'(st_ff.sp + 8'h01);
					end
					op_decimal_flag_set_op: nxt_st.status[FLG_D] = 1'b1;
					op_decimal_flag_clear_op: nxt_st.status[FLG_D] = 1'b0;
					op_carry_set: nxt_st.status[FLG_C] = 1'b1;
					op_carry_clear: nxt_st.status[FLG_C] = 1'b0;
					op_mem_mode_set: nxt_st.status[FLG_T] = 1'b1;
					op_mem_mode_clear: nxt_st.status[FLG_T] = 1'b0;
					op_product_op, op_quotient_op: begin
						nxt_st.acc = alu_res;
						nxt_st.idx = alu_res_hi;
					end
					default: begin
						if (is_rmw(st_ff.op)) begin
							// Write-back happens even for write-only targets
							mem_we = 1'b1;
							mem_wa = st_ff.mptr;
							mem_wd = alu_res;
							nxt_st.open_bus = alu_res;
						end else if (is_combine(st_ff.op) && st_ff.status[FLG_T]) begin
							mem_we = 1'b1;
							mem_wa = st_ff.idx;
							mem_wd = alu_res;
							nxt_st.open_bus = alu_res;
						end else if (is_combine(st_ff.op)) begin
							nxt_st.acc = alu_res;
						end
						if (is_rmw(st_ff.op) || is_combine(st_ff.op)) begin
							if (alu_upd_c) begin
								nxt_st.status[FLG_C] = alu_c;
							end
							// Decimal add and subtract leave N, V and Z as they were
							if (alu_upd_zn) begin
								nxt_st.status[FLG_Z] = (alu_res == 8'h00);
								nxt_st.status[FLG_N] = alu_res[7];
							end
							if (alu_upd_v) begin
								nxt_st.status[FLG_V] = alu_v;
							end
						end
					end
				endcase
			end
			default: nxt_st.fsm = st_idle;
		endcase
	end

	always_ff @(posedge REF_CLK or negedge RST_B) begin
		if (!RST_B) begin
			nxt_st_reset: begin
				st_ff.fsm <= st_idle;
				st_ff.op <= op_none;
				st_ff.bitsel <= 3'h0;
				st_ff.acc <= BYTE_RST;
				st_ff.idx <= BYTE_RST;
				st_ff.status <= STAT_RST;
				st_ff.sp <= SP_RST;
				st_ff.mptr <= BYTE_RST;
				st_ff.tmp_a <= BYTE_RST;
				st_ff.tmp_b <= BYTE_RST;
				st_ff.open_bus <= BYTE_RST;
				st_ff.busy <= 1'b0;
				st_ff.waitrequest <= 1'b1;
				st_ff.readdata <= 32'h0000_0000;
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Data array has no reset; its content is software's business
	always_ff @(posedge REF_CLK) begin
		if (mem_we) begin
			mem_ff[mem_wa] <= mem_wd;
		end
	end

	assign AVS_READDATA = st_ff.readdata;
	assign AVS_WAITREQUEST = st_ff.waitrequest;
	assign STATUS_WORD = st_ff.status;
	assign CORE_BUSY = st_ff.busy;

	// Checking helpers
	logic in_exec;
	logic bcd_ok;
	logic bcd_carry_exp;
	assign in_exec = st_ff.fsm == st_exec;
	assign bcd_ok = st_ff.tmp_a[3:0] < 4'hA && st_ff.tmp_a[7:4] < 4'hA && st_ff.tmp_b[3:0] < 4'hA
		&& st_ff.tmp_b[7:4] < 4'hA;
	assign bcd_carry_exp = (int'(st_ff.tmp_a[7:4]) * 10 + int'(st_ff.tmp_a[3:0]) + int'(st_ff.tmp_b[7:4]) * 10
		+ int'(st_ff.tmp_b[3:0]) + int'(st_ff.status[FLG_C])) > 99;

	a_reset_int_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		!$past(RST_B) |-> st_ff.status[FLG_I] && st_ff.fsm == st_idle)
		else $error("interrupt-disable flag not set after reset");
	a_push_stack_word: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_push_status |=> mem_ff[8'(st_ff.sp + 8'h01)] == $past(st_ff.status)
		&& st_ff.sp == 8'($past(st_ff.sp) - 8'h01))
		else $error("pushed status not found at SP+1");
	a_pull_restores_word: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		st_ff.fsm == st_fetch && st_ff.op == op_pull_status && !is_wo(8'(st_ff.sp + 8'h01))
		|-> ##2 st_ff.status == mem_ff[st_ff.sp])
		else $error("pulled status differs from stack byte");
	a_dflag_set_op: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_decimal_flag_set_op |=> st_ff.status[FLG_D] && !st_ff.busy)
		else $error("decimal flag not set");
	a_decimal_carry_out: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_add_with_carry && st_ff.status[FLG_D] && bcd_ok
		|=> st_ff.status[FLG_C] == $past(bcd_carry_exp))
		else $error("decimal carry wrong");
	a_decimal_nzv_kept: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.status[FLG_D] && (st_ff.op == op_add_with_carry || st_ff.op == op_subtract_with_borrow)
		|=> {st_ff.status[FLG_N], st_ff.status[FLG_V], st_ff.status[FLG_Z]}
		== $past({st_ff.status[FLG_N], st_ff.status[FLG_V], st_ff.status[FLG_Z]}))
		else $error("decimal op disturbed N, V or Z");
	a_muldiv_flags_kept: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		st_ff.fsm == st_fetch && (st_ff.op == op_product_op || st_ff.op == op_quotient_op)
		|-> ##2 st_ff.status == $past(st_ff.status, 2))
		else $error("multiply or divide changed status");
	a_product_binary: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_product_op
		|=> {st_ff.idx, st_ff.acc} == 16'($past(st_ff.acc) * $past(st_ff.tmp_b)))
		else $error("product not binary register form");
	a_rmw_write_back: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && is_rmw(st_ff.op) |-> mem_we && mem_wa == st_ff.mptr && mem_wd == alu_res)
		else $error("read-modify-write missed its write-back");
	a_tmode_to_memory: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && is_combine(st_ff.op) && st_ff.status[FLG_T]
		|=> mem_ff[$past(st_ff.idx)] == $past(alu_res) && st_ff.acc == $past(st_ff.acc))
		else $error("memory-operand result not in memory");
	a_wo_read_open: assert property (@(posedge REF_CLK) disable iff (!RST_B)
		AVS_READ && st_ff.waitrequest && st_ff.fsm == st_idle && {AVS_ADDRESS[4:2], 2'b00} == OFF_MDATA
		&& is_wo(st_ff.mptr) |=> AVS_READDATA[7:0] == $past(st_ff.open_bus) && !AVS_WAITREQUEST)
		else $error("write-only read not from internal bus");

	c_decimal_add: cover property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_add_with_carry && st_ff.status[FLG_D]);
	c_push_pull: cover property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && st_ff.op == op_pull_status);
	c_tmode_combine: cover property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && is_combine(st_ff.op) && st_ff.status[FLG_T]);
	c_wo_rmw: cover property (@(posedge REF_CLK) disable iff (!RST_B)
		in_exec && is_rmw(st_ff.op) && is_wo(st_ff.mptr));
endmodule

// ---- test/cpu_status_flag_alu_tb_top.sv ----
`timescale 1ns/1ps
module cpu_status_flag_alu_tb_top;
	import csfa_pkg::*;

	logic REF_CLK;
	logic RST_B;
	logic [AVS_AW-1:0] AVS_ADDRESS;
	logic AVS_READ;
	logic AVS_WRITE;
	logic [31:0] AVS_WRITEDATA;
	logic [3:0] AVS_BYTEENABLE;
	logic [31:0] AVS_READDATA;
	logic AVS_WAITREQUEST;
	logic [7:0] STATUS_WORD;
	logic CORE_BUSY;
	int miscompares = 0;
	int check_count = 0;

	// Decimal cases: add rows then subtract rows, carry in and out
	csfa_op_t bcd_op[6] = '{op_add_with_carry, op_add_with_carry, op_add_with_carry,
		op_subtract_with_borrow, op_subtract_with_borrow, op_subtract_with_borrow};
	logic [7:0] bcd_a[6] = '{8'h45, 8'h58, 8'h99, 8'h45, 8'h12, 8'h50};
	logic [7:0] bcd_m[6] = '{8'h38, 8'h46, 8'h01, 8'h12, 8'h45, 8'h01};
	logic bcd_ci[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [7:0] bcd_r[6] = '{8'h83, 8'h05, 8'h00, 8'h33, 8'h67, 8'h48};
	logic bcd_co[6] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	// Read-modify-write cases on the byte 96 with carry set beforehand
	csfa_op_t rmw_op[9] = '{op_clear_bit, op_set_bit, op_shift_left_arith, op_logical_shift_right,
		op_rotate_left, op_rotate_right, op_nibble_rotate, op_subtract_one, op_add_one};
	logic [2:0] rmw_bs[9] = '{3'h2, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
	logic [7:0] rmw_r[9] = '{8'h92, 8'h97, 8'h2C, 8'h4B, 8'h2D, 8'hCB, 8'h69, 8'h95, 8'h97};
	logic rmw_c[9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
	// Memory-operand combine cases: 34 op 12 with carry set
	csfa_op_t cmb_op[5] = '{op_add_with_carry, op_subtract_with_borrow, op_and, op_exclusive_or,
		op_inclusive_or};
	logic [7:0] cmb_r[5] = '{8'h47, 8'h22, 8'h10, 8'h26, 8'h36};
	logic [7:0] mdstat[2] = '{8'h00, 8'hEB};

	csfa_core #(
		.MEM_DEPTH(256)
	) i_csfa_core (
		.REF_CLK(REF_CLK),
		.RST_B(RST_B),
		.AVS_ADDRESS(AVS_ADDRESS),
		.AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE),
		.AVS_WRITEDATA(AVS_WRITEDATA),
		.AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA),
		.AVS_WAITREQUEST(AVS_WAITREQUEST),
		.STATUS_WORD(STATUS_WORD),
		.CORE_BUSY(CORE_BUSY)
	);

	initial begin
		REF_CLK = 1'b0;
		forever #50 REF_CLK = ~REF_CLK;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One access; held until waitrequest is seen low, also while a command still runs
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge REF_CLK);
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= !wr;
		AVS_WRITEDATA <= d;
		// No cycle count assumed; only the watchdog ends a wait that never gets its answer
		do begin
			@(posedge REF_CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask

	task automatic rdm(input logic [4:0] a, input logic [31:0] mask, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & mask, exp);
	endtask

	task automatic op(input csfa_op_t o, input logic [2:0] bs);
		logic [31:0] q;
		bus(1'b1, OFF_CMD, {21'h0, bs, 3'h0, o}, q);
		// Accepted command keeps the core busy through the acknowledge cycle
		chk({31'h0, CORE_BUSY}, 32'h1);
	endtask

	task automatic setm(input logic [7:0] a, input logic [7:0] d);
		wr(OFF_MPTR, a);
		wr(OFF_MDATA, d);
	endtask

	initial begin
		repeat (5000) @(posedge REF_CLK);
		miscompares++;
		complete_run();
	end

	initial begin
		RST_B = 1'b0;
		AVS_ADDRESS = '0;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h0;
		AVS_BYTEENABLE = 4'hF;
		repeat (16) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		chk({31'h0, STATUS_WORD[FLG_I]}, 32'h1);
		rdm(OFF_STAT, 32'h04, 32'h04);
		$display("test reset done");

		// Unmapped offset reads zero and swallows writes
		wr(5'h1C, 8'h5A);
		rdm(5'h1C, 32'hFFFF_FFFF, 32'h0);
		$display("test unmapped done");

		wr(OFF_SP, 8'h80);
		wr(OFF_STAT, 8'hA5);
		op(op_push_status, 3'h0);
		rdm(OFF_SP, 32'hFFFF_FFFF, 32'h7F);
		wr(OFF_MPTR, 8'h80);
		rdm(OFF_MDATA, 32'hFFFF_FFFF, 32'hA5);
		wr(OFF_STAT, 8'h5A);
		op(op_pull_status, 3'h0);
		rdm(OFF_STAT, 32'hFFFF_FFFF, 32'hA5);
		chk({24'h0, STATUS_WORD}, 32'hA5);
		rdm(OFF_SP, 32'hFFFF_FFFF, 32'h80);
		$display("test push pull done");

		wr(OFF_STAT, 8'h00);
		op(op_decimal_flag_set_op, 3'h0);
		rdm(OFF_STAT, 32'h08, 32'h08);
		// Only result and carry are compared; N, V and Z carry no meaning here
		for (int i = 0; i < 6; i++) begin
			op(bcd_ci[i] ? op_carry_set : op_carry_clear, 3'h0);
			wr(OFF_ACC, bcd_a[i]);
			setm(8'h20, bcd_m[i]);
			op(bcd_op[i], 3'h0);
			rdm(OFF_ACC, 32'hFFFF_FFFF, {24'h0, bcd_r[i]});
			rdm(OFF_STAT, 32'h01, {31'h0, bcd_co[i]});
		end
		// Same add in binary gives a different byte
		op(op_decimal_flag_clear_op, 3'h0);
		op(op_carry_clear, 3'h0);
		wr(OFF_ACC, 8'h45);
		setm(8'h20, 8'h38);
		op(op_add_with_carry, 3'h0);
		rdm(OFF_ACC, 32'hFFFF_FFFF, 32'h7D);
		$display("test decimal done");

		for (int i = 0; i < 2; i++) begin
			wr(OFF_STAT, mdstat[i]);
			wr(OFF_ACC, 8'h12);
			setm(8'h20, 8'h34);
			op(op_product_op, 3'h0);
			rdm(OFF_ACC, 32'hFFFF_FFFF, 32'hA8);
			rdm(OFF_IDX, 32'hFFFF_FFFF, 32'h03);
			rdm(OFF_STAT, 32'hFFFF_FFFF, {24'h0, mdstat[i]});
			wr(OFF_ACC, 8'hA9);
			op(op_quotient_op, 3'h0);
			rdm(OFF_ACC, 32'hFFFF_FFFF, 32'h12);
			rdm(OFF_IDX, 32'hFFFF_FFFF, 32'h01);
			rdm(OFF_STAT, 32'hFFFF_FFFF, {24'h0, mdstat[i]});
		end
		$display("test multiply divide done");

		for (int i = 0; i < 9; i++) begin
			wr(OFF_STAT, 8'h01);
			setm(8'h20, 8'h96);
			op(rmw_op[i], rmw_bs[i]);
			rdm(OFF_MDATA, 32'hFFFF_FFFF, {24'h0, rmw_r[i]});
			rdm(OFF_STAT, 32'h01, {31'h0, rmw_c[i]});
		end
		$display("test read modify write done");

		wr(OFF_IDX, 8'h30);
		wr(OFF_ACC, 8'h55);
		setm(8'h31, 8'h12);
		for (int i = 0; i < 5; i++) begin
			wr(OFF_STAT, 8'h21);
			setm(8'h30, 8'h34);
			wr(OFF_MPTR, 8'h31);
			op(cmb_op[i], 3'h0);
			wr(OFF_MPTR, 8'h30);
			rdm(OFF_MDATA, 32'hFFFF_FFFF, {24'h0, cmb_r[i]});
			rdm(OFF_ACC, 32'hFFFF_FFFF, 32'h55);
		end
		$display("test memory operand done");

		// Write-only place reads the last internal bus byte, not what was stored there
		wr(OFF_STAT, 8'h00);
		setm(8'hF5, 8'h3C);
		setm(8'h40, 8'hA7);
		wr(OFF_MPTR, 8'hF5);
		rdm(OFF_MDATA, 32'hFFFF_FFFF, 32'hA7);
		op(op_add_one, 3'h0);
		rdm(OFF_MDATA, 32'hFFFF_FFFF, 32'hA8);
		$display("test write only done");

		// Second reset in mid-run; the interrupt-disable flag was clear before it
		RST_B <= 1'b0;
		repeat (2) @(posedge REF_CLK);
		RST_B <= 1'b1;
		@(posedge REF_CLK);
		chk({31'h0, STATUS_WORD[FLG_I]}, 32'h1);
		rdm(OFF_STAT, 32'h04, 32'h04);
		rdm(OFF_SP, 32'hFFFF_FFFF, {24'h0, SP_RST});
		$display("test second reset done");

		complete_run();
	end
endmodule
